// *** rtl/csflog_top.v ***
// Top of the two-channel status and fault log register bank
// Status byte: 7 pass transistor on, 6 general pin, 5 short live, 4 enabled,
// 3 power bad, 2 overcurrent, 1 undervoltage, 0 overvoltage.
// Fault byte: 7:6 read zero, 5 down to 0 are the sticky flags in the same order, bit 4 an enable change.
// Reads answer one cycle later; a read and a write of one byte in a cycle return the old value.
//
`timescale 1ns/100ps
`default_nettype none
`include "csflog_map.vh"
module csflog_top (
  input  wire       CLK,
  input  wire       SYS_RST,
  input  wire       REG_WR,
  input  wire       REG_RD,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  output reg        REG_RVALID,
  input  wire       CH1_PASS_TRANSISTOR_ON,
  input  wire       GENERAL_PIN_ONE,
  input  wire       CH1_SHORT_DETECT,
  input  wire       CHANNEL_ONE_ENABLE_PIN_N,
  input  wire       CH1_POWER_FEEDBACK_INPUT,
  input  wire       CH1_OVERCURRENT,
  input  wire       CH1_UNDERVOLTAGE_INPUT,
  input  wire       CH1_OVERVOLTAGE_INPUT,
  input  wire       CH2_PASS_TRANSISTOR_ON,
  input  wire       GENERAL_PIN_TWO,
  input  wire       CH2_SHORT_DETECT,
  input  wire       CHANNEL_TWO_ENABLE_PIN_N,
  input  wire       CH2_POWER_FEEDBACK_INPUT,
  input  wire       CH2_OVERCURRENT,
  input  wire       CH2_UNDERVOLTAGE_INPUT,
  input  wire       CH2_OVERVOLTAGE_INPUT,
  output wire [7:0] CH1_FAULT_LOG,
  output wire [7:0] CH2_FAULT_LOG
);
  wire [7:0] ch1_status;
  wire [7:0] ch2_status;
  wire [7:0] ch1_fault;
  wire [7:0] ch2_fault;
  wire       sel_ch1_status;
  wire       sel_ch1_fault;
  wire       sel_ch2_status;
  wire       sel_ch2_fault;
  wire       ch1_fault_wr;
  wire       ch2_fault_wr;
  reg  [7:0] next_rdata;
  reg  [7:0] next_rdata_hold;
  reg        next_rvalid;

  ////////////////////////////////////////////////////////////////
  // Exact byte compare; the bank is sparse, so a partial decode would alias other bytes
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Picks one byte by its select; nothing selected reads as zero
  function [7:0] pick_byte;
    input       hit_s1;
    input       hit_f1;
    input       hit_s2;
    input       hit_f2;
    input [7:0] s1;
    input [7:0] f1;
    input [7:0] s2;
    input [7:0] f2;
    begin
      if (hit_s1) begin
        pick_byte = s1;
      end else if (hit_f1) begin
        pick_byte = f1;
      end else if (hit_s2) begin
        pick_byte = s2;
      end else if (hit_f2) begin
        pick_byte = f2;
      end else begin
        pick_byte = `CSFLOG_UNMAPPED_READ;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  assign sel_ch1_status = addr_hit(REG_ADDR, `CSFLOG_ADDR_CH1_STATUS);
  assign sel_ch1_fault  = addr_hit(REG_ADDR, `CSFLOG_ADDR_CH1_FAULT);
  assign sel_ch2_status = addr_hit(REG_ADDR, `CSFLOG_ADDR_CH2_STATUS);
  assign sel_ch2_fault  = addr_hit(REG_ADDR, `CSFLOG_ADDR_CH2_FAULT);

  // Writes to status addresses are dropped, the bytes are read-only
  assign ch1_fault_wr = REG_WR & sel_ch1_fault;
  assign ch2_fault_wr = REG_WR & sel_ch2_fault;

  assign CH1_FAULT_LOG = ch1_fault;
  assign CH2_FAULT_LOG = ch2_fault;

  csflog_channel u_ch1 (
    .clk                  (CLK),
    .rst                  (SYS_RST),
    .fet_on               (CH1_PASS_TRANSISTOR_ON),
    .general_pin          (GENERAL_PIN_ONE),
    .short_detect         (CH1_SHORT_DETECT),
    .enable_pin_n         (CHANNEL_ONE_ENABLE_PIN_N),
    .power_feedback_input (CH1_POWER_FEEDBACK_INPUT),
    .overcurrent          (CH1_OVERCURRENT),
    .undervoltage_input   (CH1_UNDERVOLTAGE_INPUT),
    .overvoltage_input    (CH1_OVERVOLTAGE_INPUT),
    .fault_wr             (ch1_fault_wr),
    .fault_wdata          (REG_WDATA),
    .status               (ch1_status),
    .fault                (ch1_fault)
  );

  csflog_channel u_ch2 (
    .clk                  (CLK),
    .rst                  (SYS_RST),
    .fet_on               (CH2_PASS_TRANSISTOR_ON),
    .general_pin          (GENERAL_PIN_TWO),
    .short_detect         (CH2_SHORT_DETECT),
    .enable_pin_n         (CHANNEL_TWO_ENABLE_PIN_N),
    .power_feedback_input (CH2_POWER_FEEDBACK_INPUT),
    .overcurrent          (CH2_OVERCURRENT),
    .undervoltage_input   (CH2_UNDERVOLTAGE_INPUT),
    .overvoltage_input    (CH2_OVERVOLTAGE_INPUT),
    .fault_wr             (ch2_fault_wr),
    .fault_wdata          (REG_WDATA),
    .status               (ch2_status),
    .fault                (ch2_fault)
  );

  ////////////////////////////////////////////////////////////////
  always @* begin
    next_rdata = pick_byte(sel_ch1_status, sel_ch1_fault, sel_ch2_status, sel_ch2_fault,
                           ch1_status, ch1_fault, ch2_status, ch2_fault);
    next_rvalid = REG_RD;
    // Without a read strobe the last byte stands, so a slow host may fetch it late
    if (REG_RD) begin
      next_rdata_hold = next_rdata;
    end else begin
      next_rdata_hold = REG_RDATA;
    end
  end

  // Read data is registered so the byte is a clean snapshot of the live bits
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= next_rvalid;
      REG_RDATA  <= next_rdata_hold;
    end
  end
endmodule
`default_nettype wire

// *** rtl/csflog_map.vh ***
// Register offsets, field positions and reset values for the channel status and fault log bank
`ifndef CSFLOG_MAP_VH
`define CSFLOG_MAP_VH
`define CSFLOG_ADDR_CH1_STATUS 8'hD2
`define CSFLOG_ADDR_CH1_FAULT  8'hD3
`define CSFLOG_ADDR_CH2_STATUS 8'hD6
`define CSFLOG_ADDR_CH2_FAULT  8'hD7
`define CSFLOG_BIT_FET_ON      7
`define CSFLOG_BIT_GPIN        6
`define CSFLOG_BIT_SHORT       5
`define CSFLOG_BIT_ENABLE      4
`define CSFLOG_BIT_PWR_BAD     3
`define CSFLOG_BIT_OVERCUR     2
`define CSFLOG_BIT_UNDERV      1
`define CSFLOG_BIT_OVERV       0
`define CSFLOG_FAULT_MASK      8'h3F
`define CSFLOG_FAULT_RESET     8'h00
`define CSFLOG_UNMAPPED_READ   8'h00
`endif

// *** rtl/csflog_channel.v ***
// One channel: live status byte and sticky fault log byte
`timescale 1ns/100ps
`default_nettype none
`include "csflog_map.vh"
module csflog_channel (
  input  wire       clk,
  input  wire       rst,
  input  wire       fet_on,
  input  wire       general_pin,
  input  wire       short_detect,
  input  wire       enable_pin_n,
  input  wire       power_feedback_input,
  input  wire       overcurrent,
  input  wire       undervoltage_input,
  input  wire       overvoltage_input,
  input  wire       fault_wr,
  input  wire [7:0] fault_wdata,
  output wire [7:0] status,
  output reg  [7:0] fault
);
  reg        prev_en_n;
  reg        prev_fb;
  reg        prev_uv;
  reg        prev_ov;
  reg        primed;
  wire [7:0] events;
  wire [7:0] next_fault;

  ////////////////////////////////////////////////////////////////
  assign status[`CSFLOG_BIT_FET_ON]  = fet_on;
  assign status[`CSFLOG_BIT_GPIN]    = general_pin;
  assign status[`CSFLOG_BIT_SHORT]   = short_detect;
  assign status[`CSFLOG_BIT_ENABLE]  = ~enable_pin_n;
  assign status[`CSFLOG_BIT_PWR_BAD] = ~power_feedback_input;
  assign status[`CSFLOG_BIT_OVERCUR] = overcurrent;
  assign status[`CSFLOG_BIT_UNDERV]  = ~undervoltage_input;
  assign status[`CSFLOG_BIT_OVERV]   = overvoltage_input;

  ////////////////////////////////////////////////////////////////
  // Edge detectors are held off until the first sample after reset, so power-up is no event
  assign events[7:6] = 2'b00;
  assign events[`CSFLOG_BIT_SHORT]   = short_detect & ~fet_on;
  assign events[`CSFLOG_BIT_ENABLE]  = primed & (enable_pin_n ^ prev_en_n);
  assign events[`CSFLOG_BIT_PWR_BAD] = primed & prev_fb & ~power_feedback_input;
  assign events[`CSFLOG_BIT_OVERCUR] = overcurrent;
  assign events[`CSFLOG_BIT_UNDERV]  = primed & prev_uv & ~undervoltage_input;
  assign events[`CSFLOG_BIT_OVERV]   = primed & ~prev_ov & overvoltage_input;

  // Set wins over a host write of zero in the same cycle
  assign next_fault = ((fault_wr ? fault_wdata : fault) | events) & `CSFLOG_FAULT_MASK;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fault     <= `CSFLOG_FAULT_RESET;
      prev_en_n <= 1'b1;
      prev_fb   <= 1'b1;
      prev_uv   <= 1'b1;
      prev_ov   <= 1'b0;
      primed    <= 1'b0;
    end else begin
      fault     <= next_fault;
      prev_en_n <= enable_pin_n;
      prev_fb   <= power_feedback_input;
      prev_uv   <= undervoltage_input;
      prev_ov   <= overvoltage_input;
      primed    <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** dv/csflog_top_sva.sv ***
// Concurrent checks on the ports of the status and fault log bank
`timescale 1ns/100ps
`default_nettype none
module csflog_top_sva (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic       REG_RVALID,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] CH1_FAULT_LOG,
  input wire logic [7:0] CH2_FAULT_LOG,
  input wire logic       CH1_PASS_TRANSISTOR_ON,
  input wire logic       GENERAL_PIN_ONE,
  input wire logic       CH1_SHORT_DETECT,
  input wire logic       CHANNEL_ONE_ENABLE_PIN_N,
  input wire logic       CH1_POWER_FEEDBACK_INPUT,
  input wire logic       CH1_OVERCURRENT,
  input wire logic       CH1_UNDERVOLTAGE_INPUT,
  input wire logic       CH1_OVERVOLTAGE_INPUT
);
  wire logic [7:0] st1 = {CH1_PASS_TRANSISTOR_ON, GENERAL_PIN_ONE, CH1_SHORT_DETECT, CHANNEL_ONE_ENABLE_PIN_N,
    CH1_POWER_FEEDBACK_INPUT, CH1_OVERCURRENT, CH1_UNDERVOLTAGE_INPUT, CH1_OVERVOLTAGE_INPUT} ^ 8'h1a;
  logic up;
  // Edge flags need a previous sample, so they are only judged from the second edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) up <= 1'b0;
    else up <= 1'b1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  read_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
  status_read_a: assert property (REG_RD && REG_ADDR == 8'hd2 |=> REG_RDATA == $past(st1))
    else $error("bad status");
  fault_read_a: assert property (REG_RD && REG_ADDR == 8'hd3 |=> REG_RDATA == $past(CH1_FAULT_LOG)) else $error("bad log");
  rsvd_zero_a: assert property ((CH1_FAULT_LOG | CH2_FAULT_LOG) < 8'h40) else $error("reserved set");
  short_flag_a: assert property (CH1_SHORT_DETECT && !CH1_PASS_TRANSISTOR_ON |=> CH1_FAULT_LOG[5]) else $error("short");
  en_change_a: assert property (up && $changed(CHANNEL_ONE_ENABLE_PIN_N) |=> CH1_FAULT_LOG[4]) else $error("enable");
  pbad_flag_a: assert property (up && $fell(CH1_POWER_FEEDBACK_INPUT) |=> CH1_FAULT_LOG[3]) else $error("pbad");
  oc_flag_a: assert property (CH1_OVERCURRENT |=> CH1_FAULT_LOG[2]) else $error("overcurrent");
  uv_flag_a: assert property (up && $fell(CH1_UNDERVOLTAGE_INPUT) |=> CH1_FAULT_LOG[1]) else $error("uv");
  ov_flag_a: assert property (up && $rose(CH1_OVERVOLTAGE_INPUT) |=> CH1_FAULT_LOG[0]) else $error("ov");
  flag_sticky_a: assert property (!(REG_WR && REG_ADDR == 8'hd3) |=>
    (CH1_FAULT_LOG & $past(CH1_FAULT_LOG)) == $past(CH1_FAULT_LOG)) else $error("flag lost");
  cover property (REG_RD && REG_ADDR == 8'hd2);
  cover property (REG_WR && REG_ADDR == 8'hd3);
  cover property (up && $changed(CHANNEL_ONE_ENABLE_PIN_N));
endmodule
bind csflog_top csflog_top_sva u_csflog_top_sva (
  .CLK                      (CLK),
  .SYS_RST                  (SYS_RST),
  .REG_WR                   (REG_WR),
  .REG_RD                   (REG_RD),
  .REG_RVALID               (REG_RVALID),
  .REG_ADDR                 (REG_ADDR),
  .REG_RDATA                (REG_RDATA),
  .CH1_FAULT_LOG            (CH1_FAULT_LOG),
  .CH2_FAULT_LOG            (CH2_FAULT_LOG),
  .CH1_PASS_TRANSISTOR_ON   (CH1_PASS_TRANSISTOR_ON),
  .GENERAL_PIN_ONE          (GENERAL_PIN_ONE),
  .CH1_SHORT_DETECT         (CH1_SHORT_DETECT),
  .CHANNEL_ONE_ENABLE_PIN_N (CHANNEL_ONE_ENABLE_PIN_N),
  .CH1_POWER_FEEDBACK_INPUT (CH1_POWER_FEEDBACK_INPUT),
  .CH1_OVERCURRENT          (CH1_OVERCURRENT),
  .CH1_UNDERVOLTAGE_INPUT   (CH1_UNDERVOLTAGE_INPUT),
  .CH1_OVERVOLTAGE_INPUT    (CH1_OVERVOLTAGE_INPUT)
);
`default_nettype wire

// *** dv/csflog_host.sv ***
// Host side model issuing single byte register reads and writes
`timescale 1ns/100ps
`default_nettype none
module csflog_host (
  input  wire logic       CLK,
  output var  logic       REG_WR,
  output var  logic       REG_RD,
  output var  logic [7:0] REG_ADDR,
  output var  logic [7:0] REG_WDATA
);
  initial {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
  // One request per cycle, held a full cycle; a write of 0 is how flags are cleared
  task automatic acc(input logic r, w, input logic [7:0] a, d);
    @(negedge CLK);
    {REG_RD, REG_WR, REG_ADDR, REG_WDATA} = {r, w, a, d};
  endtask
endmodule
`default_nettype wire

// *** dv/channel_status_fault_log_tb.sv ***
// Self-checking bench for the status and fault log bank
`timescale 1ns/100ps
`default_nettype none
module channel_status_fault_log_tb;
  logic       CLK = 0, SYS_RST = 1, wr, rd_stb, rv;
  logic [7:0] c1 = 8'h8a, c2 = 8'h8a, rdata, addr, wdata, f1, f2, q[$];
  logic [7:0] masks[6] = '{8'ha0, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  int         fails = 0, cmp_count = 0, cyc = 0;
  always #25 CLK = ~CLK;
  csflog_host u_csflog_host (.CLK(CLK), .REG_WR(wr), .REG_RD(rd_stb), .REG_ADDR(addr), .REG_WDATA(wdata));
  csflog_top u_csflog_top (.CLK(CLK), .SYS_RST(SYS_RST), .REG_WR(wr), .REG_RD(rd_stb), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rv), .CH1_FAULT_LOG(f1), .CH2_FAULT_LOG(f2),
    .CH1_PASS_TRANSISTOR_ON(c1[7]), .GENERAL_PIN_ONE(c1[6]), .CH1_SHORT_DETECT(c1[5]),
    .CHANNEL_ONE_ENABLE_PIN_N(c1[4]), .CH1_POWER_FEEDBACK_INPUT(c1[3]), .CH1_OVERCURRENT(c1[2]),
    .CH1_UNDERVOLTAGE_INPUT(c1[1]), .CH1_OVERVOLTAGE_INPUT(c1[0]),
    .CH2_PASS_TRANSISTOR_ON(c2[7]), .GENERAL_PIN_TWO(c2[6]), .CH2_SHORT_DETECT(c2[5]),
    .CHANNEL_TWO_ENABLE_PIN_N(c2[4]), .CH2_POWER_FEEDBACK_INPUT(c2[3]), .CH2_OVERCURRENT(c2[2]),
    .CH2_UNDERVOLTAGE_INPUT(c2[1]), .CH2_OVERVOLTAGE_INPUT(c2[0]));
  task chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    // A read that never got its answer leaves a note behind
    if (q.size() != 0) fails++;
    $display("mismatches %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input logic [7:0] a, e);
    q.push_back(e);
    u_csflog_host.acc(1, 0, a, 0);
  endtask
  task gap(input int n);
    u_csflog_host.acc(0, 0, 0, 0);
    repeat (n) @(negedge CLK);
  endtask
  // Back to back: both clears, then the readback in the very next cycle
  task clr;
    u_csflog_host.acc(0, 1, 8'hd3, 0);
    u_csflog_host.acc(0, 1, 8'hd7, 0);
    rd(8'hd3, 0);
    chk(f1, 8'h00);
    chk(f2, 8'h00);
    gap(2);
  endtask
  always @(negedge CLK) if (rv === 1'b1) chk(rdata, q.pop_front());
  always @(posedge CLK) if (++cyc == 3000) begin
    fails++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h1afa));
    repeat (10) @(negedge CLK);
    SYS_RST = 0;
    rd(8'hd3, 0);
    rd(8'hd0, 0);
    u_csflog_host.acc(0, 1, 8'hd2, 8'hff);
    rd(8'hd2, 8'h90);
    gap(1);
    $display("test reset done");
    repeat (8) begin
      {c1, c2} = 16'($urandom);
      rd(8'hd2, c1 ^ 8'h1a);
      rd(8'hd6, c2 ^ 8'h1a);
      gap(0);
    end
    {c1, c2} = 16'h8a8a;
    gap(3);
    clr;
    $display("test status done");
    foreach (masks[i]) begin
      c1 = 8'h8a ^ masks[i];
      c2 = c1;
      gap(2);
      {c1, c2} = 16'h8a8a;
      gap(3);
      chk(f1, masks[i] & 8'h3f);
      chk(f2, masks[i] & 8'h3f);
      rd(8'hd3, masks[i] & 8'h3f);
      rd(8'hd7, masks[i] & 8'h3f);
      clr;
    end
    u_csflog_host.acc(0, 1, 8'hd7, 8'hff);
    rd(8'hd7, 8'h3f);
    gap(2);
    $display("test faults done");
    wrap_up;
  end
endmodule
`default_nettype wire
